// >>> adc_cmd_pkg.sv
// Constants, codes and carrier types of the serial command decoder.
package adc_cmd_pkg;

    // Frame shape, counted in serial clock edges.
    localparam logic [4:0] FRAME_LEN = 5'h10;
    localparam logic [4:0] CMD_LEN = 5'h04;

    // Command codes carried in the opcode nibble.
    localparam logic [3:0] OP_LAST_INPUT = 4'h7;
    localparam logic [3:0] OP_PWDN = 4'h8;
    localparam logic [3:0] OP_RD_SETUP = 4'h9;
    localparam logic [3:0] OP_WR_SETUP = 4'ha;
    localparam logic [3:0] OP_TEST_MID = 4'hb;
    localparam logic [3:0] OP_TEST_NEG = 4'hc;
    localparam logic [3:0] OP_TEST_POS = 4'hd;
    localparam logic [3:0] OP_FIFO_RD = 4'he;

    // Value of the setup register after reset.
    localparam logic [11:0] SETUP_RESET = 12'h000;

    // Sampling period lengths in serial clocks.
    localparam logic [4:0] SAMPLE_SHORT = 5'h0c;
    localparam logic [4:0] SAMPLE_LONG = 5'h18;

    // Conversion clock sources.
    localparam logic [1:0] CLK_OSC = 2'h0;
    localparam logic [1:0] CLK_SCLK = 2'h1;
    localparam logic [1:0] CLK_DIV4 = 2'h2;
    localparam logic [1:0] CLK_DIV2 = 2'h3;

    // Conversion modes.
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_REPEAT = 2'h1;
    localparam logic [1:0] MODE_SWEEP = 2'h2;
    localparam logic [1:0] MODE_RSWEEP = 2'h3;

    // Sweep orders.
    localparam logic [1:0] ORDER_ALL = 2'h0;
    localparam logic [1:0] ORDER_TWICE = 2'h1;
    localparam logic [1:0] ORDER_DOUBLED = 2'h2;
    localparam logic [1:0] ORDER_ALTERNATE = 2'h3;

    // Sweep lengths, equal to the FIFO trigger levels.
    localparam logic [3:0] TRIG_LEN_FULL = 4'h8;
    localparam logic [3:0] TRIG_LEN_3Q = 4'h6;
    localparam logic [3:0] TRIG_LEN_HALF = 4'h4;
    localparam logic [3:0] TRIG_LEN_1Q = 4'h2;

    // Field layout of the setup register, most significant field first.
    typedef struct packed {
        logic ref_internal;
        logic ref_two_volt;
        logic long_sample;
        logic [1:0] clk_src;
        logic [1:0] conv_mode;
        logic [1:0] sweep_order;
        logic eoc_pin;
        logic [1:0] trig_level;
    } setup_type;

    // One serial input frame.
    typedef struct packed {
        logic [3:0] opcode_nibble;
        logic [11:0] field;
    } frame_type;

    // Link states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01
    } link_state_type;

endpackage

// >>> adc_serial_command_config.sv
// Serial command decoder and setup register of a multichannel converter.
`timescale 1ns/1ps

// Operation
// - Sixteen-bit frames, MSB first, opcode then field.
// - Setup read sends four junk bits, then twelve.
// - Results occupy upper twelve bits, four trailing.
// - Results use unipolar straight binary coding.
// - Frame starts on chip select or strobe fall.
// - Opcodes pick analog inputs per variant.
// - Opcode 1000b enters software power-down.
// - Opcode 1001b returns setup in low bits.
// - Opcode 1010b writes setup; clock pauses tolerated.
// - Opcodes 1011b-1101b select internal test voltages.
// - Opcode 1110b reads FIFO, low nibble zero.
// - Setup register survives every power-down.
// - Bits 11-10 choose reference and its voltage.
// - Bit 9 sets sampling to 12 or 24.
// - Bits 8-7 choose the conversion clock source.
// - Bits 6-5 choose the conversion mode.
// - Bits 4-3 choose the sweep order.
// - Bit 2 makes status pin interrupt or EOC.
// - Bits 1-0 set trigger level and sweep length.
// - Input captured on rising or falling edges.
// - Output advances per edge, floats after bit sixteen.
module adc_serial_command_config
    import adc_cmd_pkg::*;
#(
    parameter bit FOUR_INPUT = 1'b0
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic nrst,
    // Serial link pins.
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic frame_strobe,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe,
    // Converter core side.
    input wire logic [11:0] result_word,
    input wire logic internal_oscillator_tick,
    input wire logic conv_busy,
    input wire logic conv_done,
    input wire logic [3:0] fifo_count,
    // Control outputs toward the converter core.
    output logic [3:0] mux_code,
    output logic sample_active,
    output logic convert_start,
    output logic conv_clk_tick,
    output logic fifo_pop,
    output logic power_down,
    output logic [2:0] sweep_input,
    // Status and setup.
    output logic status_pin,
    output logic host_dsp,
    output logic host_known,
    output setup_type conversion_setup
);

    // Tells whether an opcode starts a conversion on this variant.
    function automatic logic is_conv_op(input logic [3:0] op);
        logic in_ok;
        in_ok = (op <= OP_LAST_INPUT) && (!FOUR_INPUT || !op[0]);
        return in_ok || op == OP_TEST_MID || op == OP_TEST_NEG || op == OP_TEST_POS;
    endfunction

    // Maps a sweep step to the analog input to sample.
    function automatic logic [2:0] sweep_pick(input logic [1:0] order, input logic [2:0] step);
        logic [2:0] pick;
        pick = step;
        if (FOUR_INPUT) begin
            case (order)
                ORDER_TWICE: pick = {1'b0, step[1:0]};
                ORDER_DOUBLED: pick = {1'b0, step[2:1]};
                ORDER_ALTERNATE: pick = {2'b00, step[0]};
                default: pick = {1'b0, step[1:0]};
            endcase
        end else begin
            case (order)
                ORDER_TWICE: pick = {step[1:0], 1'b0};
                ORDER_DOUBLED: pick = {step[2:1], 1'b0};
                ORDER_ALTERNATE: pick = {1'b0, step[0], 1'b0};
                default: pick = step;
            endcase
        end
        return pick;
    endfunction

    // Pin history for edge detection.
    logic sclk_q_r, cs_q_r, fs_q_r, sclk_rise, sclk_fall, cs_fall, fs_fall;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sclk_q_r <= 1'b0;
            cs_q_r <= 1'b1;
            fs_q_r <= 1'b1;
        end else begin
            sclk_q_r <= sclk;
            cs_q_r <= cs_n;
            fs_q_r <= frame_strobe;
        end
    end

    // Edge strobes of the link pins.
    assign sclk_rise = sclk & ~sclk_q_r;
    assign sclk_fall = ~sclk & sclk_q_r;
    assign cs_fall = ~cs_n & cs_q_r;
    assign fs_fall = ~frame_strobe & fs_q_r;

    // Link state.
    link_state_type state_r, state_nxt;
    logic [4:0] bit_cnt_r, bit_cnt_nxt;
    logic [15:0] rx_r, rx_nxt, tx_r, tx_nxt;
    logic oe_r, oe_nxt, dsp_r, dsp_nxt;
    logic [3:0] op_r, op_nxt, cmd_op;
    setup_type setup_r;
    logic frame_start, active_edge, cmd_hit, frame_hit;
    frame_type frame_in;

    // Host type, frame start and link shifting.
    always_comb begin
        dsp_nxt = cs_fall ? ~frame_strobe : dsp_r;
        frame_start = (cs_fall & frame_strobe) | (dsp_r & fs_fall);
        active_edge = dsp_r ? sclk_fall : sclk_rise;
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        oe_nxt = oe_r;
        op_nxt = op_r;
        cmd_hit = 1'b0;
        frame_hit = 1'b0;
        cmd_op = {rx_r[2:0], sdi};
        frame_in = {rx_r[14:0], sdi};
        case (state_r)
            ST_IDLE: begin
                if (frame_start) begin
                    state_nxt = ST_SHIFT;
                    bit_cnt_nxt = 5'h00;
                    tx_nxt = {result_word, 4'h0};
                    oe_nxt = 1'b1;
                end
            end
            ST_SHIFT: begin
                if (!dsp_r && cs_n) begin
                    state_nxt = ST_IDLE;
                    oe_nxt = 1'b0;
                end else if (active_edge) begin
                    rx_nxt = frame_in;
                    tx_nxt = {tx_r[14:0], 1'b0};
                    bit_cnt_nxt = 5'(bit_cnt_r + 5'h01);
                    if (bit_cnt_nxt == CMD_LEN) begin
                        cmd_hit = 1'b1;
                        op_nxt = cmd_op;
                        if (cmd_op == OP_RD_SETUP) begin
                            tx_nxt = {setup_r, 4'h0};
                        end
                    end
                    if (bit_cnt_nxt == FRAME_LEN) begin
                        frame_hit = 1'b1;
                        state_nxt = ST_IDLE;
                        oe_nxt = 1'b0;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                oe_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 5'h00;
            rx_r <= 16'h0000;
            tx_r <= 16'h0000;
            oe_r <= 1'b0;
            dsp_r <= 1'b0;
            op_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
            oe_r <= oe_nxt;
            dsp_r <= dsp_nxt;
            op_r <= op_nxt;
        end
    end

    // Command execution state.
    setup_type setup_nxt;
    logic pwdn_r, pwdn_nxt, known_r, known_nxt, pop_r, pop_nxt;
    logic [3:0] mux_r, mux_nxt;

    // Opcode actions and the setup register write.
    always_comb begin
        setup_nxt = setup_r;
        pwdn_nxt = pwdn_r;
        known_nxt = known_r;
        mux_nxt = mux_r;
        pop_nxt = 1'b0;
        if (frame_start) begin
            pwdn_nxt = 1'b0;
        end
        if (cmd_hit) begin
            if (is_conv_op(cmd_op)) begin
                mux_nxt = (FOUR_INPUT && cmd_op <= OP_LAST_INPUT) ?
                    {2'b00, cmd_op[2:1]} : cmd_op;
            end
            if (cmd_op == OP_PWDN) begin
                pwdn_nxt = 1'b1;
            end
            pop_nxt = (cmd_op == OP_FIFO_RD);
        end
        if (frame_hit && op_r == OP_WR_SETUP) begin
            setup_nxt = frame_in.field;
            known_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            setup_r <= SETUP_RESET;
            pwdn_r <= 1'b0;
            known_r <= 1'b0;
            mux_r <= 4'h0;
            pop_r <= 1'b0;
        end else begin
            setup_r <= setup_nxt;
            pwdn_r <= pwdn_nxt;
            known_r <= known_nxt;
            mux_r <= mux_nxt;
            pop_r <= pop_nxt;
        end
    end

    // Sampling, conversion clock, sweep and status state.
    logic samp_r, samp_nxt, start_r, start_nxt, tick_r, tick_nxt;
    logic int_n_r, int_n_nxt, stat_r, stat_nxt, sweeping;
    logic [4:0] samp_cnt_r, samp_cnt_nxt, samp_len;
    logic [1:0] div_r, div_nxt;
    logic [2:0] step_r, step_nxt;
    logic [3:0] trig_len;

    // Sampling window, clock source, sweep stepping and the status pin.
    always_comb begin
        samp_len = setup_r.long_sample ? SAMPLE_LONG : SAMPLE_SHORT;
        case (setup_r.trig_level)
            2'h0: trig_len = TRIG_LEN_FULL;
            2'h1: trig_len = TRIG_LEN_3Q;
            2'h2: trig_len = TRIG_LEN_HALF;
            default: trig_len = TRIG_LEN_1Q;
        endcase
        sweeping = setup_r.conv_mode == MODE_SWEEP || setup_r.conv_mode == MODE_RSWEEP;
        samp_nxt = samp_r;
        samp_cnt_nxt = samp_cnt_r;
        start_nxt = 1'b0;
        if (cmd_hit && is_conv_op(cmd_op) && !samp_r) begin
            samp_nxt = 1'b1;
            samp_cnt_nxt = 5'h00;
        end else if (samp_r && active_edge) begin
            samp_cnt_nxt = 5'(samp_cnt_r + 5'h01);
            if (samp_cnt_nxt == samp_len) begin
                samp_nxt = 1'b0;
                start_nxt = 1'b1;
            end
        end
        div_nxt = sclk_rise ? 2'(div_r + 2'h1) : div_r;
        case (setup_r.clk_src)
            CLK_OSC: tick_nxt = internal_oscillator_tick;
            CLK_SCLK: tick_nxt = sclk_rise;
            CLK_DIV4: tick_nxt = sclk_rise & (div_r == 2'h3);
            CLK_DIV2: tick_nxt = sclk_rise & div_r[0];
            default: tick_nxt = 1'b0;
        endcase
        step_nxt = step_r;
        if (frame_hit && op_r == OP_WR_SETUP) begin
            step_nxt = 3'h0;
        end else if (sweeping && conv_done) begin
            step_nxt = ({1'b0, step_r} == 4'(trig_len - 4'h1)) ? 3'h0 : 3'(step_r + 3'h1);
        end
        int_n_nxt = int_n_r;
        if (frame_start) begin
            int_n_nxt = 1'b1;
        end
        if ((setup_r.conv_mode == MODE_SINGLE && conv_done) ||
            (setup_r.conv_mode != MODE_SINGLE && fifo_count >= trig_len)) begin
            int_n_nxt = 1'b0;
        end
        stat_nxt = setup_r.eoc_pin ? ~conv_busy : int_n_r;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            samp_r <= 1'b0;
            samp_cnt_r <= 5'h00;
            start_r <= 1'b0;
            div_r <= 2'h0;
            tick_r <= 1'b0;
            step_r <= 3'h0;
            int_n_r <= 1'b1;
            stat_r <= 1'b1;
        end else begin
            samp_r <= samp_nxt;
            samp_cnt_r <= samp_cnt_nxt;
            start_r <= start_nxt;
            div_r <= div_nxt;
            tick_r <= tick_nxt;
            step_r <= step_nxt;
            int_n_r <= int_n_nxt;
            stat_r <= stat_nxt;
        end
    end

    // Outputs, taken from registers except sweep_input, which is decoded from step_r and the sweep order.
    assign sdo_out = tx_r[15];
    assign sdo_oe = oe_r;
    assign mux_code = mux_r;
    assign sample_active = samp_r;
    assign convert_start = start_r;
    assign conv_clk_tick = tick_r;
    assign fifo_pop = pop_r;
    assign power_down = pwdn_r;
    assign sweep_input = sweep_pick(setup_r.sweep_order, step_r);
    assign status_pin = stat_r;
    assign host_dsp = dsp_r;
    assign host_known = known_r;
    assign conversion_setup = setup_r;

endmodule

// >>> adc_cmd_props.sv
// Concurrent checks of the serial command decoder seen at its ports.
`timescale 1ns/1ps
module adc_cmd_props
    import adc_cmd_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic nrst,
    // Serial link pins.
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic frame_strobe,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    // Converter core side.
    input wire logic [11:0] result_word,
    input wire logic internal_oscillator_tick,
    input wire logic conv_done,
    // Outputs under watch.
    input wire logic sample_active,
    input wire logic convert_start,
    input wire logic conv_clk_tick,
    input wire logic fifo_pop,
    input wire logic power_down,
    input wire logic status_pin,
    input wire logic host_dsp,
    input wire setup_type conversion_setup
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    logic sclk_r;
    logic [4:0] edge_cnt_r;
    logic [4:0] edge_cnt_nxt;
    // Counts active serial clock edges while the sampling window is open.
    always_comb begin
        edge_cnt_nxt = sample_active ? edge_cnt_r : 5'h00;
        if (sample_active && (host_dsp ? (sclk_r && !sclk) : (sclk && !sclk_r))) begin
            edge_cnt_nxt = edge_cnt_r + 5'h01;
        end
    end
    // Registers the counter and the previous serial clock level.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sclk_r <= 1'b0;
            edge_cnt_r <= 5'h00;
        end else begin
            sclk_r <= sclk;
            edge_cnt_r <= edge_cnt_nxt;
        end
    end
    property p_sample_len;
        $fell(sample_active) |->
            edge_cnt_r == (conversion_setup.long_sample ? SAMPLE_LONG : SAMPLE_SHORT);
    endproperty
    a_sample_len: assert property (p_sample_len) else $error("sampling window length off");
    property p_conv_start;
        $fell(sample_active) |-> convert_start ##1 !convert_start;
    endproperty
    a_conv_start: assert property (p_conv_start) else $error("no start pulse");
    property p_pop_pulse;
        fifo_pop |-> sdo_oe ##1 !fifo_pop;
    endproperty
    a_pop_pulse: assert property (p_pop_pulse) else $error("bad fifo pop");
    property p_first_bit;
        $fell(cs_n) && frame_strobe && !sdo_oe |-> ##2 sdo_oe && sdo_out == result_word[11];
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("frame start missed");
    property p_oe_cs_high;
        (!host_dsp && cs_n) [*3] |-> !sdo_oe;
    endproperty
    a_oe_cs_high: assert property (p_oe_cs_high) else $error("drives while deselected");
    property p_pwdn_keep;
        $changed(power_down) |-> $stable(conversion_setup);
    endproperty
    a_pwdn_keep: assert property (p_pwdn_keep) else $error("setup lost");
    property p_sclk_tick;
        $rose(sclk) && !cs_n && conversion_setup.clk_src == CLK_SCLK |-> ##[1:3] conv_clk_tick;
    endproperty
    a_sclk_tick: assert property (p_sclk_tick) else $error("no serial tick");
    property p_osc_tick;
        internal_oscillator_tick && conversion_setup.clk_src == CLK_OSC |-> ##[1:2] conv_clk_tick;
    endproperty
    a_osc_tick: assert property (p_osc_tick) else $error("no oscillator tick");
    property p_int_low;
        conv_done && !conversion_setup.eoc_pin && conversion_setup.conv_mode == MODE_SINGLE
            |-> ##[1:3] !status_pin;
    endproperty
    a_int_low: assert property (p_int_low) else $error("interrupt not raised");
    c_sample: cover property ($fell(sample_active));
    c_pop: cover property (fifo_pop);
    c_dsp: cover property ($rose(host_dsp));
endmodule
bind adc_serial_command_config adc_cmd_props adc_cmd_props_i (.sys_clk, .nrst, .sclk, .cs_n,
    .frame_strobe, .sdo_out, .sdo_oe, .result_word, .internal_oscillator_tick, .conv_done,
    .sample_active, .convert_start, .conv_clk_tick, .fifo_pop, .power_down, .status_pin,
    .host_dsp, .conversion_setup);

// >>> host_port_model.sv
// Host serial port model that shifts frames in and out of the converter link.
`timescale 1ns/1ps
module host_port_model (
    // Clock.
    input wire logic sys_clk,
    // Serial link pins.
    output logic sclk,
    output logic cs_n,
    output logic frame_strobe,
    output logic sdi,
    input wire logic sdo_out,
    input wire logic sdo_oe
);
    // Idle link: clock parked low, both strobes high.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        frame_strobe = 1'b1;
        sdi = 1'b0;
    end
    // Waits whole system clocks and steps just past the edge.
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // One frame, SPI or strobe framed, of nb bits with a clock pause after bit 8.
    task automatic xfer(input bit dsp, input logic [15:0] w, input int nb, input int gap,
                        output logic [15:0] r);
        r = 16'h0000;
        if (dsp) begin
            if (cs_n) begin
                frame_strobe = 1'b0;
                tick(1);
                cs_n = 1'b0;
                tick(3);
            end
            frame_strobe = 1'b1;
            tick(3);
            frame_strobe = 1'b0;
        end else begin
            frame_strobe = 1'b1;
            cs_n = 1'b1;
            tick(3);
            cs_n = 1'b0;
        end
        tick(4);
        for (int i = 0; i < nb; i++) begin
            sdi = w[15 - i];
            if (dsp) sclk = 1'b1;
            tick(3);
            r[15 - i] = sdo_oe ? sdo_out : 1'bx;
            sclk = !dsp;
            tick(3);
            if (!dsp) sclk = 1'b0;
            if (i == 7 && gap > 0) begin
                tick(gap);
            end
        end
        cs_n = dsp ? cs_n : 1'b1;
        frame_strobe = 1'b1;
        sdi = !sdi;
        tick(3);
    endtask
endmodule

// >>> tb.sv
// Self-checking testbench of the serial command decoder.
`timescale 1ns/1ps
module tb;
    import adc_cmd_pkg::*;
    logic sys_clk, nrst, sclk, cs_n, frame_strobe, sdi, sdo_out, sdo_oe;
    logic sample_active, convert_start, conv_clk_tick, fifo_pop, power_down;
    logic status_pin, host_dsp, host_known, internal_oscillator_tick, conv_busy, conv_done;
    logic [3:0] mux_code;
    logic [3:0] fifo_count;
    logic [2:0] sweep_input;
    logic [11:0] result_word;
    logic [15:0] r;
    setup_type conversion_setup;
    int cycles, fail_count, num_checks, starts, pops;
    adc_serial_command_config #(.FOUR_INPUT(1'b0)) adc_serial_command_config_i (.sys_clk, .nrst,
        .sclk, .cs_n, .frame_strobe, .sdi, .sdo_out, .sdo_oe, .result_word,
        .internal_oscillator_tick, .conv_busy, .conv_done, .fifo_count, .mux_code,
        .sample_active, .convert_start, .conv_clk_tick, .fifo_pop, .power_down, .sweep_input,
        .status_pin, .host_dsp, .host_known, .conversion_setup);
    host_port_model host_port_model_i (.sys_clk, .sclk, .cs_n, .frame_strobe, .sdi, .sdo_out,
        .sdo_oe);
    // Free-running system clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Oscillator ticks, pulse counters and the hang limit.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        internal_oscillator_tick <= (cycles % 7 == 0);
        starts <= starts + int'(convert_start === 1'b1);
        pops <= pops + int'(fifo_pop === 1'b1);
        if (cycles == 8000) begin
            fail_count++;
            $display("wrong value at %0t: run timed out", $time);
            tally_and_finish();
        end
    end
    // Compares one value and reports a mismatch.
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Sends one whole frame.
    task automatic frame(input bit dsp, input logic [15:0] w);
        host_port_model_i.xfer(dsp, w, 16, 0, r);
    endtask
    // Reset values of the setup register and the pins.
    task automatic t_reset;
        check({4'h0, conversion_setup}, {4'h0, SETUP_RESET}, "setup reset");
        check({14'h0, sdo_oe, status_pin}, 16'h0001, "pins at reset");
        $display("test reset done");
    endtask
    // Host type write, then a setup write with a clock pause mid-frame.
    task automatic t_init;
        frame(1'b0, 16'ha000);
        check({14'h0, host_known, host_dsp}, 16'h0002, "host type");
        host_port_model_i.xfer(1'b0, 16'ha880, 16, 40, r);
        check({4'h0, conversion_setup}, 16'h0880, "paused write");
        frame(1'b0, 16'h9000);
        check({4'h0, r[11:0]}, 16'h0880, "setup read");
        $display("test init done");
    endtask
    // Input opcodes 0, 3 and 7 and every test select opcode with its result word.
    task automatic t_convert;
        logic [3:0] ops [6] = '{4'h0, 4'h3, OP_LAST_INPUT, OP_TEST_MID, OP_TEST_NEG, OP_TEST_POS};
        int s0;
        foreach (ops[k]) begin
            s0 = starts;
            result_word = {ops[k], ~ops[k], ops[k]};
            frame(1'b0, {ops[k], 12'h000});
            check({4'h0, r[15:4]}, {4'h0, result_word}, "result");
            check({12'h0, mux_code}, {12'h0, ops[k]}, "mux code");
            check(16'(starts - s0), 16'h0001, "one conversion");
        end
        $display("test convert done");
    endtask
    // FIFO reads at both ends of the code range.
    task automatic t_fifo;
        int p0;
        p0 = pops;
        result_word = 12'hfff;
        frame(1'b0, {OP_FIFO_RD, 12'h000});
        check(r, 16'hfff0, "fifo full scale");
        check(16'(pops - p0), 16'h0001, "fifo pop");
        result_word = 12'h000;
        frame(1'b0, {OP_FIFO_RD, 12'h000});
        check(r, 16'h0000, "fifo zero scale");
        $display("test fifo done");
    endtask
    // Power-down keeps the setup, the next frame wakes the device.
    task automatic t_pwdn;
        frame(1'b0, {OP_PWDN, 12'h000});
        check({15'h0, power_down}, 16'h0001, "power down");
        check({4'h0, conversion_setup}, 16'h0880, "setup kept");
        frame(1'b0, 16'h0000);
        check({15'h0, power_down}, 16'h0000, "wake");
        $display("test power down done");
    endtask
    // A write cut short by chip select leaves the setup alone.
    task automatic t_abort;
        host_port_model_i.xfer(1'b0, 16'ha0ff, 8, 0, r);
        check({4'h0, conversion_setup}, 16'h0880, "aborted write");
        $display("test abort done");
    endtask
    // End of conversion pulls the interrupt low until the next frame.
    task automatic t_status;
        conv_done = 1'b1;
        host_port_model_i.tick(1);
        conv_done = 1'b0;
        host_port_model_i.tick(3);
        check({15'h0, status_pin}, 16'h0000, "interrupt low");
        frame(1'b0, 16'h0000);
        check({15'h0, status_pin}, 16'h0001, "interrupt released");
        $display("test status done");
    endtask
    // Sweep order stepping and the FIFO level interrupt in sweep mode.
    task automatic t_sweep;
        frame(1'b0, 16'ha8cb);
        check({13'h0, sweep_input}, 16'h0000, "sweep first");
        for (int k = 0; k < 2; k++) begin
            conv_done = 1'b1;
            host_port_model_i.tick(1);
            conv_done = 1'b0;
            host_port_model_i.tick(1);
            check({13'h0, sweep_input}, {14'h0, ~k[0], 1'b0}, "sweep step");
        end
        fifo_count = 4'h1;
        host_port_model_i.tick(3);
        check({15'h0, status_pin}, 16'h0001, "below trigger");
        fifo_count = 4'h2;
        host_port_model_i.tick(3);
        check({15'h0, status_pin}, 16'h0000, "trigger reached");
        fifo_count = 4'h0;
        $display("test sweep done");
    endtask
    // Strobe framed write and read, then back to chip select framing.
    task automatic t_dsp;
        frame(1'b1, 16'ha884);
        check({3'h0, host_dsp, conversion_setup}, 16'h1884, "strobe write");
        conv_busy = 1'b1;
        host_port_model_i.tick(2);
        check({15'h0, status_pin}, 16'h0000, "end of conversion low");
        conv_busy = 1'b0;
        host_port_model_i.tick(2);
        check({15'h0, status_pin}, 16'h0001, "end of conversion high");
        frame(1'b1, 16'h9000);
        check({4'h0, r[11:0]}, 16'h0884, "strobe read");
        frame(1'b0, 16'ha880);
        check({3'h0, host_dsp, conversion_setup}, 16'h0880, "back to spi");
        $display("test dsp done");
    endtask
    // Reset, then the scenarios in turn.
    initial begin
        nrst = 1'b0;
        result_word = 12'h000;
        fifo_count = 4'h0;
        conv_busy = 1'b0;
        conv_done = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        host_port_model_i.tick(2);
        t_reset();
        t_init();
        t_convert();
        t_fifo();
        t_pwdn();
        t_abort();
        t_status();
        t_sweep();
        t_dsp();
        tally_and_finish();
    end
endmodule
